// ---- logic/umsts_top.sv ----
// Master endpoint status block: synchronised endpoint flags, DMA buffer
// empty flags, debug timeout counter and a small register port.
// Assumes endpoint flags are levels from the USB core clock domain and
// buffer levels come from DMA logic on clk.
`timescale 1ns/1ps

// Summary of operation
// - Bit 4 reads 1 when the master read endpoint is empty.
// - Bit 4 is the transmit-empty input after a two-flop synchroniser.
// - Bit 3 reads 1 when the master read DMA buffer is empty.
// - Bit 2 reads 1 when the master write DMA buffer is empty.
// - Bit 1 sets when transmit endpoint fills, clears after IN drains it.
// - Master read DMA grants only while bit 1 reads 0.
// - Bit 1 is the transmit data-set input, synchronised to clk.
// - Bit 0 sets on received data, clears once write DMA reads all.
// - Bit 0 is the receive data-set input, synchronised to clk.
// - When enabled, counter decrements per USB clock after receive empties.
module umsts_top #(
  parameter int LVL_W = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire umsts_pkg::umsts_bus_req_type bus_req,
  output logic [umsts_pkg::UMSTS_DW-1:0] rd_data,
  input wire logic tx_ep_empty_in,
  input wire logic tx_ep_dataset_in,
  input wire logic rx_ep_dataset_in,
  input wire logic usb_clk_in,
  input wire logic [LVL_W-1:0] rd_buf_level,
  input wire logic [LVL_W-1:0] wr_buf_level,
  input wire logic rd_dma_req,
  output logic rd_dma_grant,
  output logic irq
);
  import umsts_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int SYNC_W = 4;

  logic [SYNC_W-1:0] sync_q;
  logic tx_empty_s;
  logic tx_full_s;
  logic rx_data_s;
  logic usb_clk_s;
  logic usb_clk_prev;
  logic usb_tick;
  logic rx_data_prev;
  logic rx_empty_start;
  logic tx_full_prev;
  umsts_status_type status_q;
  logic ctrl_tmo_en;
  logic [UMSTS_DW-1:0] rdval;
  logic [UMSTS_IRQ_W-1:0] irq_sts;
  logic [UMSTS_IRQ_W-1:0] irq_msk;
  logic [UMSTS_IRQ_W-1:0] irq_set;
  logic [UMSTS_DW-1:0] tmo_count;
  logic tmo_expired;
  logic [1:0] live;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  // Shared by the direct read path and the indirect read-request path.
  // The counter is visible only indirectly, so a direct read gives zero.
  function automatic logic [UMSTS_DW-1:0] reg_value(
    input logic [UMSTS_AW-1:0] addr,
    input logic indirect
  );
    logic [UMSTS_DW-1:0] v;
    v = '0;
    case (addr)
      UMSTS_STATUS_OFS: v = {{(UMSTS_DW-UMSTS_STATUS_W){1'b0}}, status_q};
      UMSTS_CTRL_OFS: v[UMSTS_CTRL_TMO_EN_BIT] = ctrl_tmo_en;
      UMSTS_RDVAL_OFS: v = rdval;
      UMSTS_TMO_OFS: v = indirect ? tmo_count : '0;
      UMSTS_IRQ_STS_OFS: v = {{(UMSTS_DW-UMSTS_IRQ_W){1'b0}}, irq_sts};
      UMSTS_IRQ_MSK_OFS: v = {{(UMSTS_DW-UMSTS_IRQ_W){1'b0}}, irq_msk};
      default: v = '0;
    endcase
    return v;
  endfunction : reg_value

  // ----------------------------------------------------------------------
  // Crossing from the USB core domain
  // ----------------------------------------------------------------------
  // The USB clock itself is only sampled here; it must run below half of
  // clk or edges will be missed by the timeout counter.
  umsts_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({usb_clk_in, rx_ep_dataset_in, tx_ep_dataset_in, !tx_ep_empty_in}),
    .sync_out(sync_q)
  );

  // The empty flag crosses inverted, so the chain's zero reset reads as
  // empty; otherwise bit 4 would dip to 0 for two cycles after reset.
  assign tx_empty_s = !sync_q[0];
  assign tx_full_s = sync_q[1];
  assign rx_data_s = sync_q[2];
  assign usb_clk_s = sync_q[3];

  // Edge detectors look only at synchronised levels.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      usb_clk_prev <= 1'b0;
      rx_data_prev <= 1'b0;
      tx_full_prev <= 1'b0;
    end else begin
      usb_clk_prev <= usb_clk_s;
      rx_data_prev <= rx_data_s;
      tx_full_prev <= tx_full_s;
    end
  end

  assign usb_tick = usb_clk_s && !usb_clk_prev;
  assign rx_empty_start = rx_data_prev && !rx_data_s;

  // ----------------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------------
  // One more flop after the synchroniser keeps every bit of the word
  // aligned, at the cost of a cycle of latency.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= UMSTS_STATUS_RST;
    end else begin
      status_q.tx_ep_empty <= tx_empty_s;
      status_q.rd_buf_empty <= (rd_buf_level == '0);
      status_q.wr_buf_empty <= (wr_buf_level == '0);
      status_q.tx_ep_full <= tx_full_s;
      status_q.rx_ep_data <= rx_data_s;
    end
  end

  // ----------------------------------------------------------------------
  // Master read DMA gate
  // ----------------------------------------------------------------------
  // A grant needs the full flag low as software would see it now.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_dma_grant <= 1'b0;
    end else begin
      rd_dma_grant <= rd_dma_req && !status_q.tx_ep_full;
    end
  end

  // ----------------------------------------------------------------------
  // Timeout counter
  // ----------------------------------------------------------------------
  umsts_tmo u_tmo (
    .clk(clk),
    .rst_n(rst_n),
    .enable(ctrl_tmo_en),
    .rx_empty_start(rx_empty_start),
    .rx_data(rx_data_s),
    .usb_tick(usb_tick),
    .count(tmo_count),
    .expired(tmo_expired)
  );

  // ----------------------------------------------------------------------
  // Software writes
  // ----------------------------------------------------------------------
  // Control register: only the timeout enable is writable.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_tmo_en <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == UMSTS_CTRL_OFS) begin
      ctrl_tmo_en <= bus_req.wdata[UMSTS_CTRL_TMO_EN_BIT];
    end
  end

  // Read-request register: the register named by the written address is
  // sampled into the read-value register in the same edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdval <= '0;
    end else if (bus_req.wr && bus_req.addr == UMSTS_RDREQ_OFS) begin
      rdval <= reg_value(bus_req.wdata[UMSTS_AW-1:0], 1'b1);
    end
  end

  // Interrupt mask.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_msk <= '0;
    end else if (bus_req.wr && bus_req.addr == UMSTS_IRQ_MSK_OFS) begin
      irq_msk <= bus_req.wdata[UMSTS_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  // Events: receive data arrived, transmit endpoint drained, timeout hit.
  assign irq_set[UMSTS_IRQ_RX_BIT] = rx_data_s && !rx_data_prev;
  assign irq_set[UMSTS_IRQ_DRAIN_BIT] = tx_full_prev && !tx_full_s;
  assign irq_set[UMSTS_IRQ_TMO_BIT] = tmo_expired;

  // A set in the same cycle as a write-one clear wins, so no event is lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_sts <= '0;
    end else if (bus_req.wr && bus_req.addr == UMSTS_IRQ_STS_OFS) begin
      irq_sts <= (irq_sts & ~bus_req.wdata[UMSTS_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_sts <= irq_sts | irq_set;
    end
  end

  // Registered so the pin carries no decode glitches.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_sts | irq_set) & irq_msk);
    end
  end

  // ----------------------------------------------------------------------
  // Software reads
  // ----------------------------------------------------------------------
  // Data appear the cycle after the read strobe and only there.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (bus_req.rd) begin
      rd_data <= reg_value(bus_req.addr, 1'b0);
    end else begin
      rd_data <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Counts edges since reset so that delayed samples are all post-reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      live <= '0;
    end else if (live != 2'h3) begin
      live <= live + 2'h1;
    end
  end

  sequence s_status_read;
    bus_req.rd && bus_req.addr == UMSTS_STATUS_OFS;
  endsequence

  sequence s_tmo_request;
    bus_req.wr && bus_req.addr == UMSTS_RDREQ_OFS
      && bus_req.wdata[UMSTS_AW-1:0] == UMSTS_TMO_OFS;
  endsequence

  property p_tx_empty;
    @(posedge clk) disable iff (!rst_n)
    live == 2'h3 |-> status_q.tx_ep_empty == $past(tx_ep_empty_in, 3);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("bit 4 lost sync");

  property p_tx_full;
    @(posedge clk) disable iff (!rst_n)
    live == 2'h3 |-> status_q.tx_ep_full == $past(tx_ep_dataset_in, 3);
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("bit 1 lost sync");

  property p_rx_data;
    @(posedge clk) disable iff (!rst_n)
    live == 2'h3 |-> status_q.rx_ep_data == $past(rx_ep_dataset_in, 3);
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("bit 0 lost sync");

  property p_rd_buf;
    @(posedge clk) disable iff (!rst_n)
    live != 2'h0 |-> status_q.rd_buf_empty == ($past(rd_buf_level) == '0);
  endproperty
  a_rd_buf: assert property (p_rd_buf) else $error("bit 3 wrong");

  property p_wr_buf;
    @(posedge clk) disable iff (!rst_n)
    live != 2'h0 |-> status_q.wr_buf_empty == ($past(wr_buf_level) == '0);
  endproperty
  a_wr_buf: assert property (p_wr_buf) else $error("bit 2 wrong");

  property p_grant;
    @(posedge clk) disable iff (!rst_n)
    rd_dma_grant |-> $past(rd_dma_req) && !$past(status_q.tx_ep_full);
  endproperty
  a_grant: assert property (p_grant) else $error("grant while full");

  property p_reset_status;
    @(posedge clk)
    $past(!rst_n) && rst_n |-> status_q == UMSTS_STATUS_RST && live == 2'h0;
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("bad reset");

  property p_status_read;
    @(posedge clk) disable iff (!rst_n)
    s_status_read |=> rd_data[UMSTS_DW-1:UMSTS_STATUS_W] == '0
      && rd_data[UMSTS_STATUS_W-1:0] == $past(status_q);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read");

  property p_tmo_reset;
    @(posedge clk)
    $past(!rst_n) && rst_n |-> tmo_count == UMSTS_TMO_RST;
  endproperty
  a_tmo_reset: assert property (p_tmo_reset) else $error("count reset");

  property p_tmo_indirect;
    @(posedge clk) disable iff (!rst_n)
    s_tmo_request |=> rdval == $past(tmo_count);
  endproperty
  a_tmo_indirect: assert property (p_tmo_indirect) else $error("indirect read");

  property p_tmo_direct;
    @(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == UMSTS_TMO_OFS |=> rd_data == '0;
  endproperty
  a_tmo_direct: assert property (p_tmo_direct) else $error("direct count read");

  property p_irq_set_wins;
    @(posedge clk) disable iff (!rst_n)
    irq_set[UMSTS_IRQ_RX_BIT] |=> irq_sts[UMSTS_IRQ_RX_BIT];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost");

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
    live != 2'h0 |-> irq == |($past(irq_sts | irq_set) & $past(irq_msk));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level");

endmodule : umsts_top

// ---- logic/umsts_pkg.sv ----
// Constants and types for the master endpoint status block.
// Assumes one system clock; all offsets are word-aligned byte addresses.
package umsts_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int UMSTS_AW = 8;
  localparam int UMSTS_DW = 32;
  localparam int UMSTS_IRQ_W = 3;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [UMSTS_AW-1:0] UMSTS_STATUS_OFS = 8'h00;
  localparam logic [UMSTS_AW-1:0] UMSTS_CTRL_OFS = 8'h04;
  localparam logic [UMSTS_AW-1:0] UMSTS_RDREQ_OFS = 8'h08;
  localparam logic [UMSTS_AW-1:0] UMSTS_RDVAL_OFS = 8'h0C;
  localparam logic [UMSTS_AW-1:0] UMSTS_TMO_OFS = 8'h10;
  localparam logic [UMSTS_AW-1:0] UMSTS_IRQ_STS_OFS = 8'h14;
  localparam logic [UMSTS_AW-1:0] UMSTS_IRQ_MSK_OFS = 8'h18;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  // Packed from bit 4 down to bit 0.
  typedef struct packed {
    logic tx_ep_empty;
    logic rd_buf_empty;
    logic wr_buf_empty;
    logic tx_ep_full;
    logic rx_ep_data;
  } umsts_status_type;

  localparam int UMSTS_STATUS_W = 5;
  localparam logic [UMSTS_STATUS_W-1:0] UMSTS_STATUS_RST = 5'h1C;
  localparam logic [UMSTS_DW-1:0] UMSTS_TMO_RST = 32'hFFFFFFFF;
  localparam int UMSTS_CTRL_TMO_EN_BIT = 0;
  localparam int UMSTS_IRQ_RX_BIT = 0;
  localparam int UMSTS_IRQ_DRAIN_BIT = 1;
  localparam int UMSTS_IRQ_TMO_BIT = 2;

  // Register port request from the bus master.
  typedef struct packed {
    logic [UMSTS_AW-1:0] addr;
    logic [UMSTS_DW-1:0] wdata;
    logic wr;
    logic rd;
  } umsts_bus_req_type;

  // Timeout counter states.
  typedef enum logic [2:0] {
    UMSTS_TMO_IDLE = 3'b001,
    UMSTS_TMO_RUN = 3'b010,
    UMSTS_TMO_DONE = 3'b100
  } umsts_tmo_state_type;

endpackage : umsts_pkg

// ---- logic/umsts_sync.sv ----
// Two-flop level synchroniser, one per bit.
// Assumes the inputs are quasi-static levels from another domain.
`timescale 1ns/1ps
module umsts_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : umsts_sync

// ---- logic/umsts_tmo.sv ----
// Debug timeout down-counter stepped by sampled USB clock edges.
// Assumes usb_tick is a one-cycle pulse per USB clock rising edge.
`timescale 1ns/1ps
module umsts_tmo (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic rx_empty_start,
  input wire logic rx_data,
  input wire logic usb_tick,
  output logic [umsts_pkg::UMSTS_DW-1:0] count,
  output logic expired
);
  import umsts_pkg::*;

  umsts_tmo_state_type state;

  // ----------------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------------
  // Arrival of new receive data reloads the counter, so it only measures
  // how long the receive endpoint has stayed empty.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= UMSTS_TMO_IDLE;
      count <= UMSTS_TMO_RST;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      case (state)
        UMSTS_TMO_IDLE: begin
          if (enable && rx_empty_start) begin
            state <= UMSTS_TMO_RUN;
          end
        end
        UMSTS_TMO_RUN: begin
          if (!enable || rx_data) begin
            state <= UMSTS_TMO_IDLE;
            count <= UMSTS_TMO_RST;
          end else if (usb_tick) begin
            count <= count - 32'h00000001;
            if (count == 32'h00000001) begin
              state <= UMSTS_TMO_DONE;
              expired <= 1'b1;
            end
          end
        end
        UMSTS_TMO_DONE: begin
          if (!enable || rx_data) begin
            state <= UMSTS_TMO_IDLE;
            count <= UMSTS_TMO_RST;
          end
        end
        default: begin
          state <= UMSTS_TMO_IDLE;
        end
      endcase
    end
  end

  property p_tmo_step;
    @(posedge clk) disable iff (!rst_n)
    (state == UMSTS_TMO_RUN && enable && !rx_data && usb_tick)
      |=> count == $past(count) - 32'h00000001;
  endproperty
  a_tmo_step: assert property (p_tmo_step) else $error("timeout step wrong");

endmodule : umsts_tmo

// ---- tb/umsts_core_model.sv ----
// Behavioural model of the USB controller core's endpoint status outputs.
// Assumes the bench pulses one event input at a time, each for one clk cycle.
`timescale 1ns/1ps
module umsts_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fill_tx,
  input wire logic in_token,
  input wire logic rx_arrive,
  input wire logic rx_drain,
  output logic tx_ep_empty,
  output logic tx_ep_dataset,
  output logic rx_ep_dataset,
  output logic usb_clk
);
  // ----------------------------------------------------------------------
  // USB clock
  // ----------------------------------------------------------------------
  // A quarter of clk, offset by 3 ns so that no edge lines up with clk.
  initial begin
    usb_clk = 1'b0;
    #3;
    forever #20 usb_clk = ~usb_clk;
  end

  // ----------------------------------------------------------------------
  // Endpoint state
  // ----------------------------------------------------------------------
  // One packet fills the transmit endpoint; an IN token drains it whole.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_ep_empty <= 1'b1;
      tx_ep_dataset <= 1'b0;
    end else if (fill_tx) begin
      tx_ep_empty <= 1'b0;
      tx_ep_dataset <= 1'b1;
    end else if (in_token) begin
      tx_ep_empty <= 1'b1;
      tx_ep_dataset <= 1'b0;
    end
  end

  // Received data stays flagged until the write DMA has read all of it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_ep_dataset <= 1'b0;
    end else if (rx_arrive) begin
      rx_ep_dataset <= 1'b1;
    end else if (rx_drain) begin
      rx_ep_dataset <= 1'b0;
    end
  end
endmodule : umsts_core_model

// ---- tb/umsts_top_tb.sv ----
// Self-checking bench for the master endpoint status block.
// Assumes the core model in umsts_core_model.sv and the design package.
`timescale 1ns/1ps
module umsts_top_tb;
  import umsts_pkg::*;

  typedef struct packed {
    logic [5:0] rl;
    logic [5:0] wl;
    logic [2:0] cmd;
    logic [4:0] st;
  } umsts_row_type;

  // Commands: 0 none, 1 fill, 2 IN token, 3 rx data, 4 rx read out.
  localparam umsts_row_type ROWS [8] = '{
    '{6'h00, 6'h00, 3'h0, 5'h1C}, '{6'h05, 6'h00, 3'h0, 5'h14},
    '{6'h00, 6'h3F, 3'h0, 5'h18}, '{6'h00, 6'h00, 3'h1, 5'h0E},
    '{6'h00, 6'h00, 3'h2, 5'h1C}, '{6'h00, 6'h00, 3'h3, 5'h1D},
    '{6'h00, 6'h00, 3'h4, 5'h1C}, '{6'h01, 6'h01, 3'h0, 5'h10}};

  logic clk;
  logic rst_n;
  umsts_bus_req_type bus_req;
  logic [UMSTS_DW-1:0] rd_data;
  logic tx_empty;
  logic tx_dset;
  logic rx_dset;
  logic usb_clk;
  logic [5:0] rd_lvl;
  logic [5:0] wr_lvl;
  logic rd_dma_req;
  logic rd_dma_grant;
  logic irq;
  logic [3:0] ev;
  logic [31:0] d;
  logic [31:0] d2;
  int fails;
  int compares;

  // ----------------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------------
  umsts_top #(.LVL_W(6)) umsts_top_i (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .rd_data(rd_data), .tx_ep_empty_in(tx_empty), .tx_ep_dataset_in(tx_dset),
    .rx_ep_dataset_in(rx_dset), .usb_clk_in(usb_clk), .rd_buf_level(rd_lvl),
    .wr_buf_level(wr_lvl), .rd_dma_req(rd_dma_req), .rd_dma_grant(rd_dma_grant),
    .irq(irq));

  umsts_core_model umsts_core_model_i (.clk(clk), .rst_n(rst_n), .fill_tx(ev[0]),
    .in_token(ev[1]), .rx_arrive(ev[2]), .rx_drain(ev[3]), .tx_ep_empty(tx_empty),
    .tx_ep_dataset(tx_dset), .rx_ep_dataset(rx_dset), .usb_clk(usb_clk));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe; the slave never stalls.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= v;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    v = rd_data;
  endtask : rd_reg

  // The counter has no direct read path; go through request and value.
  task automatic rd_cnt(output logic [31:0] v);
    wr_reg(UMSTS_RDREQ_OFS, 32'h00000010);
    rd_reg(UMSTS_RDVAL_OFS, v);
  endtask : rd_cnt

  // Pulse one model event, then let three synchroniser edges pass and more.
  task automatic do_cmd(input logic [2:0] c);
    if (c != 3'h0) begin
      @(posedge clk);
      ev <= 4'h1 << (c - 3'h1);
      @(posedge clk);
      ev <= 4'h0;
    end
    repeat (5) @(posedge clk);
  endtask : do_cmd

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  // The whole sequence needs well under 2000 cycles.
  initial begin
    #100000;
    fails++;
    results();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    fails = 0;
    compares = 0;
    rst_n = 1'b0;
    bus_req = '0;
    rd_lvl = 6'h00;
    wr_lvl = 6'h00;
    rd_dma_req = 1'b0;
    ev = 4'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, a write to the read-only status and an unmapped read.
    rd_reg(UMSTS_STATUS_OFS, d);
    check(d, 32'h0000001C);
    check({31'h0, d[4]}, 32'h00000001);
    wr_reg(UMSTS_STATUS_OFS, 32'hFFFFFFFF);
    rd_reg(UMSTS_STATUS_OFS, d);
    check(d, 32'h0000001C);
    rd_cnt(d);
    check(d, 32'hFFFFFFFF);
    wr_reg(UMSTS_TMO_OFS, 32'h00000000);
    rd_reg(UMSTS_TMO_OFS, d);
    check(d, 32'h00000000);
    rd_cnt(d);
    check(d, 32'hFFFFFFFF);
    rd_reg(8'h1C, d);
    check(d, 32'h00000000);
    // Ordinary cases: buffer levels and endpoint events against status.
    for (int i = 0; i < 8; i++) begin
      rd_lvl <= ROWS[i].rl;
      wr_lvl <= ROWS[i].wl;
      do_cmd(ROWS[i].cmd);
      rd_reg(UMSTS_STATUS_OFS, d);
      check(d, {27'h0, ROWS[i].st});
    end
    rd_lvl <= 6'h00;
    wr_lvl <= 6'h00;
    // Events left sticky bits while masked; unmask, then clear by W1C.
    rd_reg(UMSTS_IRQ_STS_OFS, d);
    check(d, 32'h00000003);
    check({31'h0, irq}, 32'h00000000);
    wr_reg(UMSTS_IRQ_MSK_OFS, 32'h00000001);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h00000001);
    wr_reg(UMSTS_IRQ_STS_OFS, 32'h00000003);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h00000000);
    rd_reg(UMSTS_IRQ_STS_OFS, d);
    check(d, 32'h00000000);
    // DMA gate opens while the endpoint has room and shuts once it is full.
    rd_dma_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, rd_dma_grant}, 32'h00000001);
    do_cmd(3'h1);
    #1;
    check({31'h0, rd_dma_grant}, 32'h00000000);
    do_cmd(3'h2);
    #1;
    check({31'h0, rd_dma_grant}, 32'h00000001);
    rd_dma_req <= 1'b0;
    // Timeout counts down once receive data empties, reloads on disable.
    wr_reg(UMSTS_CTRL_OFS, 32'h00000001);
    do_cmd(3'h3);
    do_cmd(3'h4);
    // A full USB clock period after arming guarantees at least one step.
    repeat (4) @(posedge clk);
    rd_cnt(d);
    repeat (40) @(posedge clk);
    rd_cnt(d2);
    check({31'h0, d != 32'hFFFFFFFF}, 32'h00000001);
    // The captures lie 44 clk edges apart, which is 11 USB clock periods.
    check(d - d2, 32'h0000000B);
    wr_reg(UMSTS_CTRL_OFS, 32'h00000000);
    rd_cnt(d);
    check(d, 32'hFFFFFFFF);
    // Reset in mid-run with receive data pending and the gate requested.
    do_cmd(3'h3);
    rd_dma_req <= 1'b1;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check({30'h0, irq, rd_dma_grant}, 32'h00000000);
    check(rd_data, 32'h00000000);
    rst_n <= 1'b1;
    rd_dma_req <= 1'b0;
    rd_cnt(d);
    check(d, 32'hFFFFFFFF);
    results();
  end
endmodule : umsts_top_tb
